/* File: logic/rlsf_defs.vh */
// Constants for the per-port receive link status register bank.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RLSF_DEFS_VH
`define RLSF_DEFS_VH

// Register offsets on the internal register access port.
`define RLSF_ADDR_PORT_SEL 8'h4c
`define RLSF_ADDR_LINK_STS 8'h4d

// Fields of the port select register.
`define RLSF_SEL_RD_MSB 5
`define RLSF_SEL_RD_LSB 4
`define RLSF_SEL_WR_MSB 3
`define RLSF_SEL_WR_LSB 0
`define RLSF_SEL_PHYS_MSB 7
`define RLSF_SEL_PHYS_LSB 6

// Fields of the receive port link status register.
`define RLSF_STS_PORT_MSB 7
`define RLSF_STS_PORT_LSB 6
`define RLSF_BIT_CRC 5
`define RLSF_BIT_LOCK_CHG 4
`define RLSF_BIT_SEQ 3
`define RLSF_BIT_PARITY 2
`define RLSF_BIT_PASS 1
`define RLSF_BIT_LOCK 0

// Reset values.
`define RLSF_RST_SEL 6'h00
`define RLSF_RST_FLAGS 6'h00
`define RLSF_RST_BYTE 8'h00
`define RLSF_RST_PHYS 2'h0

`endif

/* File: logic/rlsf_sync.v */
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/1ps

module rlsf_sync #(
    parameter WIDTH = 8
) (
    input wire sys_clk_i, // System clock.
    input wire reset_i, // Synchronous reset, active high.
    input wire [WIDTH-1:0] async_i, // Levels from outside the clock domain.
    output reg [WIDTH-1:0] sync_o // Synchronised levels.
);

    reg [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // rlsf_sync

/* File: logic/rlsf_port_flags.v */
// Status flags of one receive port: sticky errors, lock change, parity flag.
// Assumes synchronised lock and pass levels and same-clock event pulses.
`timescale 1ns/1ps
`include "rlsf_defs.vh"

module rlsf_port_flags #(
    parameter CNT_W = 16
) (
    input wire sys_clk_i, // System clock.
    input wire reset_i, // Synchronous reset, active high.
    input wire lock_i, // Synchronised receiver lock level.
    input wire pass_i, // Synchronised pass indication level.
    input wire crc_err_i, // Control channel CRC error pulse.
    input wire seq_err_i, // Control channel sequence error pulse.
    input wire any_err_i, // Control channel any-error pulse.
    input wire enh_en_i, // Enhanced error reporting enable.
    input wire [CNT_W-1:0] par_count_i, // Parity error count.
    input wire [CNT_W-1:0] par_limit_i, // Parity error limit.
    input wire par_clear_i, // Parity count registers cleared.
    input wire sts_read_i, // Status register read for this port.
    input wire detail_read_i, // Detail status register read for this port.
    output reg [5:0] flags_o // Status bits 5 down to 0.
);

    reg lock_prev_q;
    reg [5:0] flags_d;
    wire bit3_set;
    wire bit3_clr;

    // Bit 3 takes its source and its clearing event from the enhanced enable.
    assign bit3_set = enh_en_i ? any_err_i : seq_err_i; // RL6
    assign bit3_clr = enh_en_i ? detail_read_i : sts_read_i; // RL7 RL8

    // Next flags: a set in the same cycle as a clear wins.
    always @* begin
        flags_d = flags_o;
        flags_d[`RLSF_BIT_CRC] = crc_err_i | (flags_o[`RLSF_BIT_CRC] & ~sts_read_i); // RL4 RL13
        flags_d[`RLSF_BIT_LOCK_CHG] = (lock_i ^ lock_prev_q)
            | (flags_o[`RLSF_BIT_LOCK_CHG] & ~sts_read_i); // RL5 RL13
        flags_d[`RLSF_BIT_SEQ] = bit3_set | (flags_o[`RLSF_BIT_SEQ] & ~bit3_clr); // RL7 RL8 RL13
        flags_d[`RLSF_BIT_PARITY] = (par_count_i > par_limit_i)
            | (flags_o[`RLSF_BIT_PARITY] & ~par_clear_i); // RL9 RL10
        flags_d[`RLSF_BIT_PASS] = pass_i; // RL11
        flags_d[`RLSF_BIT_LOCK] = lock_i; // RL12
    end

    // Flag and lock history registers.
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            flags_o <= `RLSF_RST_FLAGS;
            lock_prev_q <= 1'b0;
        end else begin
            flags_o <= flags_d;
            lock_prev_q <= lock_i;
        end
    end

endmodule // rlsf_port_flags

/* File: logic/rlsf_top.v */
// Receive port link status register bank with its port select register.
// Assumes an internal register access port driven by the serial host
// interface engine, one strobe per byte access, all on sys_clk_i.
// Lock and pass levels come from the receivers and are synchronised here;
// error pulses, enables and parity counts come from same-clock logic.
`timescale 1ns/1ps
`include "rlsf_defs.vh"

// Summary of operation
// RL1: Each receive port has its own status register copy and host accesses reach the selected one.
// RL2: The host picks the read port with a two-bit code, zero to three naming ports zero to three.
// RL3: The top two bits of the status byte read back the selected read port number.
// RL4: The CRC flag in bit 5 sets on a control channel CRC error and clears on read.
// RL5: The lock change flag in bit 4 sets on any lock change since the last read and clears on read.
// RL6: Bit 3 has one of two meanings chosen by the enhanced error enable.
// RL7: With enhanced reporting off, bit 3 sets on a sequence error and clears on read.
// RL8: With enhanced reporting on, bit 3 sets on any channel error and clears on a detail status read.
// RL9: The parity flag in bit 2 sets when the parity count exceeds the programmed limit.
// RL10: The parity flag survives reads and clears only when the parity counts are cleared.
// RL11: Bit 1 shows the live receiver pass indication.
// RL12: Bit 0 shows the live receiver lock state.
// RL13: An event in the same cycle as its clearing read stays set.
module rlsf_top #(
    parameter NUM_PORTS = 4,
    parameter CNT_W = 16
) (
    input wire sys_clk_i, // System clock, 40 MHz.
    input wire reset_i, // Synchronous reset, active high.
    input wire [7:0] reg_addr_i, // Register offset of the access.
    input wire reg_wr_i, // Write strobe, one cycle.
    input wire reg_rd_i, // Read strobe, one cycle.
    input wire [7:0] reg_wdata_i, // Write data.
    output reg [7:0] reg_rdata_o, // Read data, registered.
    output reg reg_rvalid_o, // Read data valid, one cycle.
    input wire [NUM_PORTS-1:0] receiver_locked_i, // Receiver lock levels, asynchronous.
    input wire [NUM_PORTS-1:0] port_pass_i, // Pass criteria met, asynchronous.
    input wire [NUM_PORTS-1:0] crc_err_i, // Control channel CRC error pulses.
    input wire [NUM_PORTS-1:0] seq_err_i, // Control channel sequence error pulses.
    input wire [NUM_PORTS-1:0] any_err_i, // Control channel any-error pulses.
    input wire [NUM_PORTS-1:0] enhanced_error_enable_i, // Enhanced reporting enables.
    input wire [NUM_PORTS*CNT_W-1:0] parity_count_i, // Parity error counts.
    input wire [NUM_PORTS*CNT_W-1:0] parity_error_limit_i, // Parity error limits.
    input wire [NUM_PORTS-1:0] parity_count_clear_i, // Parity count clear pulses.
    input wire detail_status_read_i, // Detail status read of the selected port.
    output reg [1:0] read_port_o, // Selected read port.
    output reg [NUM_PORTS-1:0] write_port_en_o // Per-port write enables.
);

    // Port select register contents.
    reg [5:0] sel_q;
    reg [5:0] sel_d;

    // Live copies of the flags, one six-bit slice per port.
    wire [NUM_PORTS*6-1:0] flags_all;
    wire [2*NUM_PORTS-1:0] live_sync;

    // Decoded accesses.
    wire sel_hit;
    wire sts_hit;
    wire [1:0] rd_port;
    wire [NUM_PORTS-1:0] sts_read_vec;
    wire [NUM_PORTS-1:0] detail_read_vec;

    // Read data path.
    reg [7:0] rdata_d;
    reg [5:0] sel_flags;

    integer k;

    // Address decode of the two registers this bank answers.
    assign sel_hit = (reg_addr_i == `RLSF_ADDR_PORT_SEL);
    assign sts_hit = (reg_addr_i == `RLSF_ADDR_LINK_STS);
    assign rd_port = sel_q[`RLSF_SEL_RD_MSB:`RLSF_SEL_RD_LSB]; // RL2

    // Lock and pass levels cross into the clock domain before use.
    rlsf_sync #(
        .WIDTH(2*NUM_PORTS)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i({port_pass_i, receiver_locked_i}),
        .sync_o(live_sync)
    );

    // One flag set per receive port; read clears reach only the selected copy, parity count clears reach each port's own copy.
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            // Port number of this copy, sized to match the read port field.
            localparam [1:0] PORT_NUM = p;
            assign sts_read_vec[p] = reg_rd_i & sts_hit & (rd_port == PORT_NUM); // RL1
            assign detail_read_vec[p] = detail_status_read_i & (rd_port == PORT_NUM); // RL8

            rlsf_port_flags #(
                .CNT_W(CNT_W)
            ) u_flags (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .lock_i(live_sync[p]),
                .pass_i(live_sync[NUM_PORTS+p]),
                .crc_err_i(crc_err_i[p]),
                .seq_err_i(seq_err_i[p]),
                .any_err_i(any_err_i[p]),
                .enh_en_i(enhanced_error_enable_i[p]),
                .par_count_i(parity_count_i[p*CNT_W +: CNT_W]),
                .par_limit_i(parity_error_limit_i[p*CNT_W +: CNT_W]),
                .par_clear_i(parity_count_clear_i[p]),
                .sts_read_i(sts_read_vec[p]),
                .detail_read_i(detail_read_vec[p]),
                .flags_o(flags_all[p*6 +: 6])
            );
        end
    endgenerate

    // Port select write; only the read port and write enable fields are stored.
    always @* begin
        sel_d = sel_q;
        if (reg_wr_i && sel_hit) begin
            sel_d = reg_wdata_i[5:0]; // RL2
        end
    end

    // Pick the flags of the selected read port.
    always @* begin
        sel_flags = `RLSF_RST_FLAGS;
        for (k = 0; k < NUM_PORTS; k = k + 1) begin
            if (rd_port == k[1:0]) begin
                sel_flags = flags_all[k*6 +: 6]; // RL1
            end
        end
    end

    // Read data; unmapped offsets read as zero and writes to status are ignored.
    always @* begin
        rdata_d = `RLSF_RST_BYTE;
        if (sel_hit) begin
            rdata_d[`RLSF_SEL_PHYS_MSB:`RLSF_SEL_PHYS_LSB] = `RLSF_RST_PHYS;
            rdata_d[5:0] = sel_q;
        end else if (sts_hit) begin
            rdata_d[`RLSF_STS_PORT_MSB:`RLSF_STS_PORT_LSB] = rd_port; // RL3
            rdata_d[5:0] = sel_flags;
        end
    end

    // Registers and registered outputs.
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            sel_q <= `RLSF_RST_SEL;
            reg_rdata_o <= `RLSF_RST_BYTE;
            reg_rvalid_o <= 1'b0;
            read_port_o <= 2'h0;
            write_port_en_o <= {NUM_PORTS{1'b0}};
        end else begin
            sel_q <= sel_d;
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
            read_port_o <= sel_d[`RLSF_SEL_RD_MSB:`RLSF_SEL_RD_LSB];
            write_port_en_o <= sel_d[NUM_PORTS-1:0];
        end
    end

endmodule // rlsf_top

/* File: bench/rlsf_top_props.sv */
// Checker for the receive link status bank, bound to its top module.
// Assumes four ports and a read answer one cycle after the strobe.
`timescale 1ns/1ps
module rlsf_top_props #(
    parameter NUM_PORTS = 4,
    parameter CNT_W = 16
) (
    input wire sys_clk_i, // Clock.
    input wire reset_i, // Reset.
    input wire [7:0] reg_addr_i, // Offset.
    input wire reg_wr_i, // Write.
    input wire reg_rd_i, // Read.
    input wire [7:0] reg_wdata_i, // Data in.
    input wire [7:0] reg_rdata_o, // Data out.
    input wire reg_rvalid_o, // Answer.
    input wire [NUM_PORTS-1:0] receiver_locked_i, // Lock.
    input wire [NUM_PORTS-1:0] port_pass_i, // Pass.
    input wire [NUM_PORTS-1:0] crc_err_i, // CRC.
    input wire [NUM_PORTS-1:0] seq_err_i, // Sequence.
    input wire [NUM_PORTS-1:0] any_err_i, // Any error.
    input wire [NUM_PORTS-1:0] enhanced_error_enable_i, // Mode.
    input wire [NUM_PORTS*CNT_W-1:0] parity_count_i, // Counts.
    input wire [NUM_PORTS*CNT_W-1:0] parity_error_limit_i, // Limits.
    input wire [NUM_PORTS-1:0] parity_count_clear_i, // Clears.
    input wire detail_status_read_i, // Detail read.
    input wire [1:0] read_port_o, // Read port.
    input wire [NUM_PORTS-1:0] write_port_en_o // Write enables.
);
    // Selected port, status read and that port's parity figures.
    wire [1:0] rp = read_port_o;
    wire rd_sts = reg_rd_i && (reg_addr_i == 8'h4d);
    wire [CNT_W-1:0] cnt = parity_count_i[rp*CNT_W +: CNT_W];
    wire [CNT_W-1:0] lim = parity_error_limit_i[rp*CNT_W +: CNT_W];
    default clocking dcb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // Read sequences that set or clear the sticky flags.
    sequence s_crc_read;
        crc_err_i[rp] && !reg_wr_i ##1 rd_sts;
    endsequence
    sequence s_quiet_reread;
        rd_sts && !reg_wr_i && !crc_err_i[rp] ##1 !reg_wr_i && !crc_err_i[rp] ##1 rd_sts;
    endsequence
    sequence s_crc_on_read;
        crc_err_i[rp] && rd_sts && !reg_wr_i ##1 !reg_wr_i ##1 rd_sts;
    endsequence
    sequence s_enh_reread;
        enhanced_error_enable_i[rp] && rd_sts && !reg_wr_i && !detail_status_read_i
        ##1 enhanced_error_enable_i[rp] && !reg_wr_i && !detail_status_read_i && reg_rdata_o[3]
        ##1 enhanced_error_enable_i[rp] && rd_sts;
    endsequence
    AST_SEL: assert property (reg_wr_i && reg_addr_i == 8'h4c |=>
        {read_port_o, write_port_en_o} == $past(reg_wdata_i[5:0])) else $error("select wrong");
    AST_PORTNUM: assert property (rd_sts |=> reg_rdata_o[7:6] == $past(rp))
        else $error("port number wrong");
    AST_CRC: assert property (s_crc_read |=> reg_rdata_o[5]) else $error("crc flag lost");
    AST_CLEAR: assert property (s_quiet_reread |=> !reg_rdata_o[5])
        else $error("crc flag not cleared");
    AST_KEEP: assert property (s_crc_on_read |=> reg_rdata_o[5]) else $error("event lost");
    AST_SEQ: assert property (!enhanced_error_enable_i[rp] && seq_err_i[rp] && !reg_wr_i
        ##1 !enhanced_error_enable_i[rp] && rd_sts |=> reg_rdata_o[3]) else $error("seq lost");
    AST_ENH: assert property (s_enh_reread |=> reg_rdata_o[3]) else $error("bit 3 cleared");
    AST_PAR: assert property ((cnt > lim) && !reg_wr_i ##1 rd_sts |=> reg_rdata_o[2])
        else $error("parity flag low");
endmodule // rlsf_top_props
bind rlsf_top rlsf_top_props #(.NUM_PORTS(NUM_PORTS), .CNT_W(CNT_W)) rlsf_top_props_inst (.*);

/* File: bench/rlsf_host_model.sv */
// Host model: byte register accesses with one strobe cycle each.
// Assumes the read answer comes exactly one cycle after the strobe.
`timescale 1ns/1ps
module rlsf_host_model (
    input wire sys_clk_i, // Clock.
    input wire [7:0] rdata_i, // Read data.
    input wire rvalid_i, // Answer valid.
    output logic [7:0] addr_o = 8'h00, // Offset.
    output logic wr_o = 1'b0, // Write strobe.
    output logic rd_o = 1'b0, // Read strobe.
    output logic [7:0] wdata_o = 8'h00 // Write data.
);
    // Strobe for one cycle, scramble released lines, then take the answer.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic ok);
        @(posedge sys_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge sys_clk_i);
        addr_o <= ~a;
        wdata_o <= ~d;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        #1;
        q = rdata_i;
        ok = w | (rvalid_i === 1'b1);
    endtask
endmodule // rlsf_host_model

/* File: bench/rx_link_status_flags_tb.sv */
// Testbench for the receive link status bank through the host model.
// Assumes a 40 MHz clock and the one-cycle read answer.
`timescale 1ns/1ps
module rx_link_status_flags_tb;
    logic clk = 1'b0, reset = 1'b1, det = 1'b0;
    logic [3:0] locked = 4'h0, pass = 4'h0, crc = 4'h0, seq = 4'h0, anyv = 4'h0;
    logic [3:0] enh = 4'h0, pclr = 4'h0, wen;
    logic [63:0] pcnt = 64'h0, plim = 64'h0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid;
    logic [1:0] rport;
    int miscompares = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    rlsf_top rlsf_top_inst (.sys_clk_i(clk), .reset_i(reset), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .receiver_locked_i(locked), .port_pass_i(pass),
        .crc_err_i(crc), .seq_err_i(seq), .any_err_i(anyv), .enhanced_error_enable_i(enh),
        .parity_count_i(pcnt), .parity_error_limit_i(plim), .parity_count_clear_i(pclr),
        .detail_status_read_i(det), .read_port_o(rport), .write_port_en_o(wen));
    rlsf_host_model rlsf_host_model_inst (.sys_clk_i(clk), .rdata_i(rdata),
        .rvalid_i(rvalid), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
            miscompares++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic ok;
        rlsf_host_model_inst.access(1'b0, a, 8'h00, q, ok);
        chk("answer", 8'h01, {7'h00, ok});
        chk("read data", e, q);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        rlsf_host_model_inst.access(1'b1, a, d, q, ok);
    endtask
    // Events for one cycle, the status read in the next.
    task automatic ev_rd(input logic [3:0] c, s, a, input logic [7:0] e);
        @(posedge clk);
        {crc, seq, anyv} <= {c, s, a};
        fork
            rdc(8'h4d, e);
            begin
                @(posedge clk);
                {crc, seq, anyv} <= 12'h000;
            end
        join
    endtask
    task automatic end_of_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence of tests.
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdc(8'h4d, 8'h00);
        rdc(8'h4c, 8'h00);
        $display("reset values done");
        @(posedge clk);
        {locked, pass} <= 8'hff;
        repeat (5) @(posedge clk);
        ev_rd(4'hf, 4'hf, 4'h0, 8'h3b);
        for (int p = 0; p < 4; p++) begin
            wrr(8'h4c, {2'b00, p[1:0], 4'h1 << p});
            chk("select", {2'b00, p[1:0], 4'h1 << p}, {2'b00, rport, wen});
            if (p > 0) rdc(8'h4d, {p[1:0], 6'h3b});
            rdc(8'h4d, {p[1:0], 6'h03});
        end
        rdc(8'h4c, 8'h38);
        $display("per-port flags done");
        fork
            rdc(8'h4d, 8'hc3);
            begin
                @(posedge clk);
                crc <= 4'h8;
                @(posedge clk);
                crc <= 4'h0;
            end
        join
        rdc(8'h4d, 8'he3);
        @(posedge clk);
        enh <= 4'h8;
        ev_rd(4'h0, 4'h8, 4'h0, 8'hc3);
        ev_rd(4'h0, 4'h0, 4'h8, 8'hcb);
        rdc(8'h4d, 8'hcb);
        @(posedge clk);
        det <= 1'b1;
        @(posedge clk);
        det <= 1'b0;
        rdc(8'h4d, 8'hc3);
        $display("bit 3 modes done");
        @(posedge clk);
        {plim[48+:16], pcnt[48+:16]} <= {16'h0005, 16'h0005};
        rdc(8'h4d, 8'hc3);
        @(posedge clk);
        pcnt[48+:16] <= 16'h0006;
        rdc(8'h4d, 8'hc7);
        @(posedge clk);
        pcnt[48+:16] <= 16'h0000;
        rdc(8'h4d, 8'hc7);
        @(posedge clk);
        pclr <= 4'h8;
        @(posedge clk);
        pclr <= 4'h0;
        rdc(8'h4d, 8'hc3);
        $display("parity flag done");
        @(posedge clk);
        locked <= 4'h7;
        wrr(8'h4d, 8'hff);
        repeat (4) @(posedge clk);
        rdc(8'h4e, 8'h00);
        rdc(8'h4d, 8'hd2);
        $display("lock loss and decode done");
        end_of_test();
    end
endmodule // rx_link_status_flags_tb
